// File: inc/fmsp_pkg.sv
`default_nettype none
package fmsp_pkg;
  // bus geometry
  localparam int          FMSP_AW        = 12;
  localparam logic [1:0]  FMSP_RESP_OKAY = 2'h0;
  localparam logic [1:0]  FMSP_RESP_SLV  = 2'h2;
  // register indices; byte address is four times the index
  localparam logic [9:0]  FMSP_IDX_CTRL  = 10'h098;
  localparam logic [9:0]  FMSP_IDX_BUF   = 10'h099;
  localparam logic [9:0]  FMSP_IDX_CFG   = 10'h09A;
  localparam logic [7:0]  FMSP_BUF_RESET = 8'h00;
  // control register fields
  localparam int FMSP_B_MODE_HI = 7;
  localparam int FMSP_B_MODE_LO = 6;
  localparam int FMSP_B_MP_EN   = 5;
  localparam int FMSP_B_REN     = 4;
  localparam int FMSP_B_TB8     = 3;
  localparam int FMSP_B_RB8     = 2;
  localparam int FMSP_B_TI      = 1;
  localparam int FMSP_B_RI      = 0;
  // config register fields
  localparam int FMSP_B_DOUBLE  = 7;
  localparam int FMSP_B_TX_T2   = 1;
  localparam int FMSP_B_RX_T2   = 0;
  localparam int FMSP_B_RELOAD  = 8;
  // timing
  localparam int          FMSP_CLK_MHZ   = 100;
  localparam int          FMSP_M0_DIV    = 12;
  localparam logic [3:0]  FMSP_OVS_LAST  = 4'hF;
  localparam logic [3:0]  FMSP_OVS_MID   = 4'h7;
  localparam logic [7:0]  FMSP_T1_TOP    = 8'hFF;
  // bits after the start bit, stop included; for mode zero, bits after the first of eight
  localparam logic [3:0]  FMSP_BITS_8    = 4'h9;
  localparam logic [3:0]  FMSP_BITS_9    = 4'hA;
  localparam logic [3:0]  FMSP_M0_BITS   = 4'h7;

  typedef enum logic [1:0] {FMSP_TX_IDLE, FMSP_TX_WAIT, FMSP_TX_SEND, FMSP_TX_M0} fmsp_tx_t;
  typedef enum logic [1:0] {FMSP_RX_IDLE, FMSP_RX_START, FMSP_RX_DATA} fmsp_rx_t;

  typedef struct packed {
    logic               awready;
    logic               wready;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [1:0]         rresp;
    logic [31:0]        rdata;
    logic               aw_got;
    logic               w_got;
    logic [FMSP_AW-1:0] waddr;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               mode_hi;
    logic               mode_lo;
    logic               mp_en;
    logic               ren;
    logic               tb8;
    logic               rb8;
    logic               ti;
    logic               ri;
    logic [7:0]         rx_buf;
    logic               rate_double;
    logic               tx_t2;
    logic               rx_t2;
    logic [7:0]         reload;
    logic [7:0]         t1_cnt;
    logic               t1_half;
    logic               clk_half;
    fmsp_tx_t           tx_state;
    logic [10:0]        tx_sh;
    logic [3:0]         tx_left;
    logic [3:0]         tx_div;
    logic [3:0]         m0_phase;
    logic               m0_rx;
    logic               txd;
    logic               rxd_out;
    logic               rxd_oe;
    fmsp_rx_t           rx_state;
    logic [3:0]         rx_div;
    logic [3:0]         rx_left;
    logic [9:0]         rx_sh;
    logic [2:0]         rx_sync;
    logic               rx_f;
    logic               rx_prev;
  } fmsp_state_t;
endpackage
`default_nettype wire

// File: rtl/fmsp_serial_port.sv
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module fmsp_serial_port
  import fmsp_pkg::*;
#(
  parameter int M0_DIV = FMSP_M0_DIV
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [FMSP_AW-1:0] s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output var  logic               s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output var  logic               s_axi_wready,
  output var  logic [1:0]         s_axi_bresp,
  output var  logic               s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [FMSP_AW-1:0] s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output var  logic               s_axi_arready,
  output var  logic [31:0]        s_axi_rdata,
  output var  logic [1:0]         s_axi_rresp,
  output var  logic               s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               timer2_overflow,
  input  wire logic               rxd_in,
  output var  logic               rxd_out,
  output var  logic               rxd_oe,
  output var  logic               txd
);
  localparam logic [3:0] M0_LAST = 4'(M0_DIV - 1);
  localparam logic [3:0] M0_MID  = 4'(M0_DIV / 2);

  if (M0_DIV < 2 || M0_DIV > 16 || (M0_DIV % 2) != 0) begin : g_bad_div
    $error("M0_DIV must be even and within 2..16");
  end

  // 0 none, 1 control, 2 buffer, 3 config
  function automatic logic [1:0] reg_sel(input logic [FMSP_AW-1:0] a);
    logic [9:0] idx;
    idx = a[FMSP_AW-1:2];
    if (idx == FMSP_IDX_CTRL) return 2'h1;
    if (idx == FMSP_IDX_BUF) return 2'h2;
    if (idx == FMSP_IDX_CFG) return 2'h3;
    return 2'h0;
  endfunction

  fmsp_state_t st;
  fmsp_state_t next_st;
  logic        wr_buf;
  logic        wr_ctrl;
  logic        async_mode;
  logic        nine_bit;
  logic        tx_tick;
  logic        rx_tick;
  logic        tx_bit;

  always_comb begin
    logic       t1_ovf;
    logic       t1_tick;
    logic       fix_tick;
    logic       set_ti;
    logic       set_ri;
    logic       set_rb8;
    logic       rb8_val;
    logic       do_wr;
    logic [1:0] wsel;
    logic [9:0] nsh;
    logic       ninth;
    t1_ovf   = 1'b0;
    t1_tick  = 1'b0;
    fix_tick = 1'b0;
    set_ti   = 1'b0;
    set_ri   = 1'b0;
    set_rb8  = 1'b0;
    rb8_val  = 1'b0;
    do_wr    = 1'b0;
    wsel     = 2'h0;
    nsh      = '0;
    ninth    = 1'b0;
    next_st  = st;

    async_mode = st.mode_hi | st.mode_lo;
    nine_bit   = st.mode_hi;
    do_wr      = st.aw_got && st.w_got && !st.bvalid;
    wsel       = reg_sel(st.waddr);
    wr_buf     = do_wr && wsel == 2'h2 && st.wstrb[0];
    wr_ctrl    = do_wr && wsel == 2'h1 && st.wstrb[0];

    // timer one runs in 8-bit autoreload off the core clock
    t1_ovf = st.t1_cnt == FMSP_T1_TOP;
    next_st.t1_cnt = t1_ovf ? st.reload : 8'(st.t1_cnt + 8'h01);
    if (t1_ovf) begin
      next_st.t1_half = ~st.t1_half;
    end
    next_st.clk_half = ~st.clk_half;
    // the 16x tick: halving it is what the rate bit undoes
    t1_tick  = t1_ovf && (st.rate_double || st.t1_half);
    fix_tick = st.rate_double || st.clk_half;
    if (st.mode_hi && !st.mode_lo) begin
      tx_tick = fix_tick;
      rx_tick = fix_tick;
    end else begin
      tx_tick = st.tx_t2 ? timer2_overflow : t1_tick;
      rx_tick = st.rx_t2 ? timer2_overflow : t1_tick;
    end
    if (tx_tick) begin
      next_st.tx_div = 4'(st.tx_div + 4'h1);
    end
    tx_bit = tx_tick && st.tx_div == FMSP_OVS_LAST;

    // pin synchroniser; a level counts once stages two and three agree
    next_st.rx_sync = {st.rx_sync[1:0], rxd_in};
    if (st.rx_sync[1] == st.rx_sync[2]) begin
      next_st.rx_f = st.rx_sync[2];
    end

    // transmitter and mode zero engine
    case (st.tx_state)
      FMSP_TX_IDLE: begin
        next_st.txd    = 1'b1;
        next_st.rxd_oe = 1'b0;
        if (wr_buf) begin
          if (async_mode) begin
            // a 1 in the ninth slot serves as stop in the 8-bit mode
            next_st.tx_sh    = {1'b1, nine_bit ? st.tb8 : 1'b1, st.wdata[7:0], 1'b0};
            next_st.tx_state = FMSP_TX_WAIT;
          end else begin
            next_st.tx_sh    = {3'h7, st.wdata[7:0]};
            next_st.m0_rx    = 1'b0;
            next_st.rxd_out  = st.wdata[0];
            next_st.rxd_oe   = 1'b1;
            next_st.tx_state = FMSP_TX_M0;
          end
        end else if (!async_mode && st.ren && !st.ri) begin
          next_st.m0_rx    = 1'b1;
          next_st.tx_state = FMSP_TX_M0;
        end
        if (next_st.tx_state == FMSP_TX_M0) begin
          next_st.m0_phase = 4'h0;
          next_st.tx_left  = FMSP_M0_BITS;
          next_st.txd      = 1'b0;
        end
      end
      FMSP_TX_WAIT: begin
        if (tx_bit) begin
          next_st.txd      = st.tx_sh[0];
          next_st.tx_sh    = {1'b1, st.tx_sh[10:1]};
          next_st.tx_left  = nine_bit ? FMSP_BITS_9 : FMSP_BITS_8;
          next_st.tx_state = FMSP_TX_SEND;
        end
      end
      FMSP_TX_SEND: begin
        if (tx_bit) begin
          if (st.tx_left == 4'h0) begin
            next_st.txd      = 1'b1;
            next_st.tx_state = FMSP_TX_IDLE;
          end else begin
            next_st.txd     = st.tx_sh[0];
            next_st.tx_sh   = {1'b1, st.tx_sh[10:1]};
            next_st.tx_left = 4'(st.tx_left - 4'h1);
            set_ti          = st.tx_left == 4'h1;
          end
        end
      end
      FMSP_TX_M0: begin
        next_st.m0_phase = (st.m0_phase == M0_LAST) ? 4'h0 : 4'(st.m0_phase + 4'h1);
        next_st.txd      = next_st.m0_phase >= M0_MID;
        if (st.m0_rx && st.m0_phase == M0_MID) begin
          next_st.tx_sh[7:0] = {st.rx_f, st.tx_sh[7:1]};
        end
        if (st.m0_phase == M0_LAST) begin
          if (st.tx_left == 4'h0) begin
            next_st.txd      = 1'b1;
            next_st.rxd_oe   = 1'b0;
            next_st.tx_state = FMSP_TX_IDLE;
            if (st.m0_rx) begin
              set_ri         = 1'b1;
              next_st.rx_buf = st.tx_sh[7:0];
            end else begin
              set_ti = 1'b1;
            end
          end else begin
            next_st.tx_left = 4'(st.tx_left - 4'h1);
            if (!st.m0_rx) begin
              next_st.tx_sh   = {1'b1, st.tx_sh[10:1]};
              next_st.rxd_out = st.tx_sh[1];
            end
          end
        end
      end
      default: next_st.tx_state = FMSP_TX_IDLE;
    endcase

    // asynchronous receiver, sampling at 16x the bit rate
    if (rx_tick) begin
      next_st.rx_prev = st.rx_f;
      next_st.rx_div  = 4'(st.rx_div + 4'h1);
    end
    case (st.rx_state)
      FMSP_RX_IDLE: begin
        if (rx_tick && async_mode && st.ren && st.rx_prev && !st.rx_f) begin
          next_st.rx_div   = 4'h0;
          next_st.rx_state = FMSP_RX_START;
        end
      end
      FMSP_RX_START: begin
        // glitches shorter than half a bit are dropped here
        if (rx_tick && st.rx_div == FMSP_OVS_MID) begin
          next_st.rx_div   = 4'h0;
          next_st.rx_left  = nine_bit ? FMSP_BITS_9 : FMSP_BITS_8;
          next_st.rx_state = st.rx_f ? FMSP_RX_IDLE : FMSP_RX_DATA;
        end
      end
      FMSP_RX_DATA: begin
        if (rx_tick && st.rx_div == FMSP_OVS_LAST) begin
          nsh             = {st.rx_f, st.rx_sh[9:1]};
          next_st.rx_sh   = nsh;
          next_st.rx_left = 4'(st.rx_left - 4'h1);
          if (st.rx_left == 4'h1) begin
            next_st.rx_state = FMSP_RX_IDLE;
            ninth = nine_bit ? nsh[8] : nsh[9];
            if (!st.ri && nsh[9] && !(nine_bit && st.mp_en && !ninth)) begin
              set_ri         = 1'b1;
              set_rb8        = 1'b1;
              rb8_val        = ninth;
              next_st.rx_buf = nine_bit ? nsh[7:0] : nsh[8:1];
            end
          end
        end
      end
      default: next_st.rx_state = FMSP_RX_IDLE;
    endcase

    // AXI4-Lite write side
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_got = 1'b1;
      next_st.waddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (do_wr) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = (wsel == 2'h0) ? FMSP_RESP_SLV : FMSP_RESP_OKAY;
      if (wr_ctrl) begin
        next_st.mode_hi = st.wdata[FMSP_B_MODE_HI];
        next_st.mode_lo = st.wdata[FMSP_B_MODE_LO];
        next_st.mp_en   = st.wdata[FMSP_B_MP_EN];
        next_st.ren     = st.wdata[FMSP_B_REN];
        next_st.tb8     = st.wdata[FMSP_B_TB8];
        next_st.rb8     = st.wdata[FMSP_B_RB8];
        next_st.ti      = st.wdata[FMSP_B_TI];
        next_st.ri      = st.wdata[FMSP_B_RI];
      end
      if (wsel == 2'h3 && st.wstrb[0]) begin
        next_st.rate_double = st.wdata[FMSP_B_DOUBLE];
        next_st.tx_t2       = st.wdata[FMSP_B_TX_T2];
        next_st.rx_t2       = st.wdata[FMSP_B_RX_T2];
      end
      if (wsel == 2'h3 && st.wstrb[1]) begin
        next_st.reload = st.wdata[FMSP_B_RELOAD +: 8];
      end
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    // hardware events win over a software clear in the same cycle
    if (set_ti) begin
      next_st.ti = 1'b1;
    end
    if (set_ri) begin
      next_st.ri = 1'b1;
    end
    if (set_rb8) begin
      next_st.rb8 = rb8_val;
    end
    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready  = !next_st.w_got && !next_st.bvalid;

    // AXI4-Lite read side
    if (s_axi_arvalid && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid  = 1'b1;
      next_st.rresp   = FMSP_RESP_OKAY;
      case (reg_sel(s_axi_araddr))
        2'h1: next_st.rdata = {24'h0, st.mode_hi, st.mode_lo, st.mp_en, st.ren,
                               st.tb8, st.rb8, st.ti, st.ri};
        2'h2: next_st.rdata = {24'h0, st.rx_buf};
        2'h3: next_st.rdata = {16'h0, st.reload, st.rate_double, 5'h0, st.tx_t2, st.rx_t2};
        default: begin
          next_st.rdata = 32'h0;
          next_st.rresp = FMSP_RESP_SLV;
        end
      endcase
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid  = 1'b0;
      next_st.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st          <= '0;
      st.awready  <= 1'b1;
      st.wready   <= 1'b1;
      st.arready  <= 1'b1;
      st.txd      <= 1'b1;
      st.rx_buf   <= FMSP_BUF_RESET;
      st.rx_sync  <= 3'h7;
      st.rx_f     <= 1'b1;
      st.rx_prev  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready  = st.wready;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_arready = st.arready;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign s_axi_rvalid  = st.rvalid;
  assign rxd_out       = st.rxd_out;
  assign rxd_oe        = st.rxd_oe;
  assign txd           = st.txd;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  txd_idle_high_a: assert property (st.tx_state == FMSP_TX_IDLE |-> st.txd)
    else $error("txd not high while idle");
  start_bit_low_a: assert property (st.tx_state == FMSP_TX_WAIT && tx_bit |=> !st.txd)
    else $error("start bit not low");
  buf_write_send_a: assert property (wr_buf && st.tx_state == FMSP_TX_IDLE && async_mode
                                     |=> st.tx_state == FMSP_TX_WAIT)
    else $error("buffer write did not start a frame");
  ti_at_stop_a: assert property ($rose(st.ti) && !$past(wr_ctrl) && $past(async_mode)
                                 |-> st.txd && st.tx_state == FMSP_TX_SEND)
    else $error("transmit flag not at stop bit");
  m0_clock_phase_a: assert property (st.tx_state == FMSP_TX_M0
                                     |-> st.txd == (st.m0_phase >= M0_MID))
    else $error("shift clock out of phase");
  m0_half_period_a: assert property ($fell(st.txd) && st.tx_state == FMSP_TX_M0
                                     |-> !st.txd [*6] ##1 st.txd)
    else $error("shift clock low time wrong");
  m0_drive_a: assert property (st.tx_state == FMSP_TX_M0 |-> st.rxd_oe == !st.m0_rx)
    else $error("data pin drive wrong in shift mode");
  rx_needs_ren_a: assert property (st.rx_state == FMSP_RX_START
                                   && $past(st.rx_state) == FMSP_RX_IDLE |-> $past(st.ren))
    else $error("receive started without enable");
  mp_ninth_a: assert property ($rose(st.ri) && !$past(wr_ctrl) && $past(st.mp_en)
                               && $past(nine_bit) && $past(async_mode) |-> st.rb8)
    else $error("flag set with ninth bit zero");
  ri_blocks_a: assert property (st.ri && !wr_ctrl |=> st.rx_buf == $past(st.rx_buf))
    else $error("buffer overwritten while flag set");
  bvalid_hold_a: assert property (st.bvalid && !s_axi_bready |=> st.bvalid)
    else $error("write response dropped");

  rx_frame_c: cover property ($rose(st.ri) && async_mode);
  m0_send_c: cover property ($rose(st.ti) && !async_mode);
  m0_recv_c: cover property (st.tx_state == FMSP_TX_M0 && st.m0_rx ##1 st.tx_state == FMSP_TX_IDLE);
  read_c: cover property (st.rvalid && s_axi_rready);
  mp_drop_c: cover property (st.rx_state == FMSP_RX_DATA && nine_bit && st.mp_en ##1 st.rx_state == FMSP_RX_IDLE);
endmodule
`default_nettype wire

// File: bench/fmsp_partner.sv
`timescale 1ns/100ps
`default_nettype none
// far end: async transceiver or shift-register peripheral
module fmsp_partner (
  input  wire logic aclk,
  input  wire logic txd,
  input  wire logic rxd_out,
  input  wire logic rxd_oe,
  output wire logic rxd_in
);
  // mode 0 async, 1 shift capture, 2 shift drive
  int         mode    = 0;
  int         bit_cyc = 16;
  logic       nine    = 1'b0;
  logic [9:0] got     = '0;
  logic [7:0] m0_pat  = 8'h00;
  int         m0_idx  = 0;
  logic       drv     = 1'b1;

  // wire resolved from both drivers; rxd_out while rxd_oe is high, else the partner's drv
  assign rxd_in = rxd_oe ? rxd_out : drv;

  always @(posedge txd) begin
    if (mode == 1 && rxd_oe) begin
      got[7:0] <= {rxd_out, got[7:1]};
    end
  end

  always @(negedge txd) begin
    if (mode == 2) begin
      // change data at clock fall so it is settled long before the rise
      drv <= (m0_idx < 8) ? m0_pat[m0_idx] : 1'b1;
      m0_idx++;
    end else if (mode == 0) begin
      repeat (bit_cyc / 2) @(posedge aclk);
      for (int i = 0; i < (nine ? 10 : 9); i++) begin
        repeat (bit_cyc) @(posedge aclk);
        got[i] = txd;
      end
    end
  end

  task automatic send(input logic [7:0] d, input logic b9, input logic stp);
    logic [10:0] f;
    f = nine ? {stp, b9, d, 1'b0} : {1'b1, stp, d, 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      @(posedge aclk);
      drv <= f[i];
      repeat (bit_cyc - 1) @(posedge aclk);
    end
    @(posedge aclk);
    drv <= 1'b1;
  endtask
endmodule
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import fmsp_pkg::*;
;
  localparam logic [11:0] a_ctrl = {FMSP_IDX_CTRL, 2'b00};
  localparam logic [11:0] a_buf  = {FMSP_IDX_BUF, 2'b00};
  localparam logic [11:0] a_cfg  = {FMSP_IDX_CFG, 2'b00};
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [11:0]       awaddr = '0;
  logic [11:0]       araddr = '0;
  logic [31:0]       wdata = '0;
  logic              awvalid = 1'b0;
  logic              wvalid = 1'b0;
  logic              bready = 1'b0;
  logic              arvalid = 1'b0;
  logic              rready = 1'b0;
  logic              t2 = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid, txd, rxd_out, rxd_oe, rxd_in;
  logic [1:0]        bresp, rresp;
  logic [31:0]       rdata, v, rnd;
  logic [1:0]        r;
  int                failures = 0;
  int                num_checks = 0;
  logic [7:0]        md [5] = '{8'h80, 8'h80, 8'h40, 8'h40, 8'hC0};
  logic [31:0]       cfg [5] = '{32'h80, 32'h0, 32'hFF80, 32'hFE00, 32'h3};
  int                per [5] = '{16, 32, 16, 64, 32};
  logic              nin [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

  fmsp_serial_port dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer2_overflow(t2), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd));
  fmsp_partner partner_u (.aclk(aclk), .txd(txd), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .rxd_in(rxd_in));

  initial begin
    forever #5 aclk = ~aclk;
  end
  // overflow pulse every second cycle
  always @(posedge aclk) t2 <= ~t2;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] exp_cap(input logic [7:0] d, input logic b9, input logic n);
    return n ? {22'h0, 1'b1, b9, d} : {22'h0, 2'b01, d};
  endfunction
  function automatic logic exp_rb8(input logic n, input logic b9);
    return n ? b9 : 1'b1;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic bh;
    int n;
    n = 0;
    bh = 1'b0;
    rs = 2'h3;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // handshakes are judged at the rising edge itself
    while (!bh && n < 100) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
      end
      if (bvalid && bready) begin
        bh = 1'b1;
        rs = bresp;
        bready <= 1'b0;
      end
      n++;
    end
    if (!bh) failures++;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic h;
    int n;
    n = 0;
    h = 1'b0;
    d = '0;
    rs = 2'h3;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!h && n < 100) begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
      end
      if (rvalid && rready) begin
        h = 1'b1;
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
      end
      n++;
    end
    if (!h) failures++;
  endtask

  task automatic wait_bit(input int b);
    logic [31:0] q;
    logic [1:0] rs;
    int n;
    n = 0;
    q = '0;
    while (q[b] !== 1'b1 && n < 3000) begin
      rd(a_ctrl, q, rs);
      n++;
    end
    if (q[b] !== 1'b1) failures++;
  endtask

  task automatic close_out();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge aclk);
    failures++;
    close_out();
  end

  initial begin
    rnd = 32'hF29B;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(a_buf, v, r);
    chk(v, 32'(FMSP_BUF_RESET));
    chk(32'(r), 32'(FMSP_RESP_OKAY));
    rd(12'h000, v, r);
    chk(32'(r), 32'(FMSP_RESP_SLV));
    wr(12'h004, 32'h55, r);
    chk(32'(r), 32'(FMSP_RESP_SLV));
    chk(32'(txd), 32'h1);
    for (int k = 0; k < 5; k++) begin
      rnd = lfsr(rnd);
      partner_u.bit_cyc = per[k];
      partner_u.nine = nin[k];
      partner_u.got = '0;
      wr(a_cfg, cfg[k], r);
      wr(a_ctrl, {24'h0, md[k] | 8'h10 | {4'h0, rnd[16], 3'h0}}, r);
      wr(a_buf, {24'h0, rnd[7:0]}, r);
      wait_bit(1);
      repeat (per[k]) @(posedge aclk);
      chk(32'(partner_u.got), exp_cap(rnd[7:0], rnd[16], nin[k]));
      partner_u.send(rnd[15:8], rnd[17], 1'b1);
      wait_bit(0);
      rd(a_buf, v, r);
      chk(v, {24'h0, rnd[15:8]});
      rd(a_ctrl, v, r);
      chk(32'(v[2]), 32'(exp_rb8(nin[k], rnd[17])));
      wr(a_ctrl, {24'h0, md[k] | 8'h10}, r);
      chk(32'(txd), 32'h1);
    end
    wr(a_cfg, 32'h80, r);
    // fixed-rate 9-bit mode so the 16-cycle bit holds
    wr(a_ctrl, 32'h90, r);
    partner_u.bit_cyc = 16;
    partner_u.nine = 1'b1;
    partner_u.send(8'h5A, 1'b1, 1'b0);
    repeat (32) @(posedge aclk);
    rd(a_ctrl, v, r);
    chk(32'(v[0]), 32'h0);
    wr(a_ctrl, 32'hB0, r);
    partner_u.send(8'h33, 1'b0, 1'b1);
    repeat (32) @(posedge aclk);
    rd(a_ctrl, v, r);
    chk(32'(v[0]), 32'h0);
    partner_u.send(8'h3C, 1'b1, 1'b1);
    wait_bit(0);
    partner_u.send(8'hC3, 1'b1, 1'b1);
    repeat (32) @(posedge aclk);
    rd(a_buf, v, r);
    chk(v, 32'h3C);
    wr(a_ctrl, 32'h80, r);
    partner_u.send(8'h81, 1'b1, 1'b1);
    repeat (32) @(posedge aclk);
    rd(a_ctrl, v, r);
    chk(32'(v[0]), 32'h0);
    rnd = lfsr(rnd);
    partner_u.mode = 1;
    partner_u.got = '0;
    wr(a_ctrl, 32'h0, r);
    wr(a_buf, {24'h0, rnd[7:0]}, r);
    wait_bit(1);
    repeat (12) @(posedge aclk);
    chk(32'(partner_u.got[7:0]), {24'h0, rnd[7:0]});
    partner_u.mode = 2;
    partner_u.m0_pat = rnd[15:8];
    partner_u.m0_idx = 0;
    wr(a_ctrl, 32'h10, r);
    wait_bit(0);
    rd(a_buf, v, r);
    chk(v, {24'h0, rnd[15:8]});
    wr(a_ctrl, 32'h0, r);
    close_out();
  end
endmodule
`default_nettype wire
